//--- afs_params.svh
/*
 constants of the analog frequency source select block: register offsets,
 reset values, setting codes and filter limits.
 assumes it is included by bare name wherever a macro is needed.
*/
`ifndef AFS_PARAMS_SVH
`define AFS_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define AFS_OFS_RUN_SRC     8'h00
`define AFS_OFS_FREQ_SRC    8'h04
`define AFS_OFS_FILTER      8'h08
`define AFS_OFS_SEL_OPT     8'h0C
`define AFS_OFS_TRIM_OPT    8'h10
`define AFS_OFS_SEL_ASSIGN  8'h14
`define AFS_OFS_STATUS      8'h18
`define AFS_OFS_FREQ_CMD    8'h1C

// ---------------------------------------------------------------
// setting codes and reset values
// ---------------------------------------------------------------
`define AFS_RUN_KEYPAD      3'h2
`define AFS_RUN_RST         3'h1
`define AFS_FREQ_ANALOG     3'h1
`define AFS_FREQ_RST        3'h1
`define AFS_FILT_MIN        5'h01
`define AFS_FILT_MAX        5'h1E
`define AFS_FILT_RST        5'h08
`define AFS_SEL_CURR        1'h0
`define AFS_SEL_BIP         1'h1
`define AFS_TRIM_NONE       2'h0
`define AFS_TRIM_UNI        2'h1
`define AFS_TRIM_REV        2'h2
`define AFS_SAMPLE_W        10
`define AFS_RAM_AW          5

`endif

//--- afs_pkg.sv
/*
 types shared by the analog frequency source select block.
 assumes afs_params.svh is on the include path.
*/
`include "afs_params.svh"

package afs_pkg;

   // primary command channel
   typedef enum logic [1:0] {
      CH_VOLT,
      CH_CURR,
      CH_BIP,
      CH_SUM
   } chan_sel_t;

   // routing decision
   typedef struct packed {
      chan_sel_t chan;
      logic      trim_en;
      logic      rev_en;
   } route_t;

   // one set of converted analog samples
   typedef struct packed {
      logic        [`AFS_SAMPLE_W-1:0] volt;
      logic        [`AFS_SAMPLE_W-1:0] curr;
      logic signed [`AFS_SAMPLE_W-1:0] bip;
   } samples_t;

endpackage

//--- afs_sample_ram.sv
/*
 sample history memory for the moving average filter.
 assumes one write and one read port on the same clock; read data registered.
*/
`timescale 1ns/1ns

module afs_sample_ram #(
   parameter int DW = 30,
   parameter int AW = 5
) (
   // clock and control
   input  wire logic          i_clk_sys,
   input  wire logic          i_clk_en,
   // write port
   input  wire logic          i_wr_en,
   input  wire logic [AW-1:0] i_wr_addr,
   input  wire logic [DW-1:0] i_wr_data,
   // read port
   input  wire logic          i_rd_en,
   input  wire logic [AW-1:0] i_rd_addr,
   output logic      [DW-1:0] o_rd_data
);

   logic [DW-1:0] mem_ff [0:(1<<AW)-1];

   always_ff @(posedge i_clk_sys) begin
      if (i_clk_en && i_wr_en) begin
         mem_ff[i_wr_addr] <= i_wr_data;
      end
      if (i_clk_en && i_rd_en) begin
         o_rd_data <= mem_ff[i_rd_addr];
      end
   end

endmodule // afs_sample_ram

//--- afs_select.sv
/*
 analog frequency source select: register port, moving average filter of the
 three analog channels, routing of command channel, trim and reverse, and the
 run source monitor output.
 assumes samples arrive from logic on i_clk_sys; the select pin is asynchronous.
*/
// Function
// - monitor on while run source is keypad
// - monitor off for any other run source
// - select inactive uses voltage channel
// - select active uses current or bipolar
// - analog command only when frequency source analog
// - one filter setting 1..30 for all
// - options and select jointly pick routing
// - option 00: no trim, bipolar reverses
// - options 01/02 add trim except on bipolar; 02 always reverses
// - bipolar sign gives rotation direction
// - unassigned select ignores select option
// - option 01 makes bipolar trim unipolar
`timescale 1ns/1ns
`include "afs_params.svh"

module afs_select #(
   parameter int W  = `AFS_SAMPLE_W,
   parameter int DW = 16
) (
   // clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_reset_n,
   input  wire logic              i_clk_en,
   // register port
   input  wire logic [7:0]        i_addr,
   input  wire logic [DW-1:0]     i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [DW-1:0]     o_rdata,
   // analog samples and select pin
   input  wire afs_pkg::samples_t i_samples,
   input  wire logic              i_sample_valid,
   input  wire logic              i_current_voltage_select_input,
   // command outputs
   output logic                   o_run_source_monitor_output,
   output logic                   o_analog_active,
   output afs_pkg::route_t        o_route,
   output logic      [W+1:0]      o_freq_cmd,
   output logic                   o_dir_reverse
);

   localparam int AW = `AFS_RAM_AW;
   localparam int SW = W + AW;
   localparam int CW = W + 3;

   typedef enum logic [1:0] {ST_IDLE, ST_UPD, ST_AVG} filt_state_t;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------
   function automatic logic [W-1:0] avg_of(input logic [SW-1:0] s, input logic [AW-1:0] n);
      logic [SW-1:0] q;
      q = (n == '0) ? '0 : s / SW'(n);
      return q[W-1:0];
   endfunction

   function automatic logic [W-1:0] flip_msb(input logic [W-1:0] v);
      return {~v[W-1], v[W-2:0]};
   endfunction

   function automatic afs_pkg::route_t route_of(input logic [1:0] opt, input logic sel_opt,
                                               input logic assigned, input logic sel);
      afs_pkg::route_t r;
      r = '{chan: afs_pkg::CH_VOLT, trim_en: 1'b0, rev_en: 1'b0};
      if (!assigned) begin
         if (opt == `AFS_TRIM_UNI || opt == `AFS_TRIM_REV) begin
            r.chan    = afs_pkg::CH_SUM;
            r.trim_en = 1'b1;
            r.rev_en  = (opt == `AFS_TRIM_REV);
         end else begin
            r.chan    = afs_pkg::CH_BIP;
            r.rev_en  = 1'b1;
         end
      end else begin
         if (!sel) begin
            r.chan = afs_pkg::CH_VOLT;
         end else if (sel_opt == `AFS_SEL_BIP) begin
            r.chan = afs_pkg::CH_BIP;
         end else begin
            r.chan = afs_pkg::CH_CURR;
         end
         r.trim_en = (opt == `AFS_TRIM_UNI || opt == `AFS_TRIM_REV)
                     && (r.chan != afs_pkg::CH_BIP);
         r.rev_en  = (opt == `AFS_TRIM_REV) || (r.chan == afs_pkg::CH_BIP);
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // registers and pin synchroniser
   // ---------------------------------------------------------------
   logic [2:0]     run_src_ff;
   logic [2:0]     freq_src_ff;
   logic [AW-1:0]  filt_ff;
   logic           sel_opt_ff;
   logic [1:0]     trim_opt_ff;
   logic           sel_assign_ff;
   logic [1:0]     sel_sync_ff;
   logic [DW-1:0]  rdata_ff;
   logic           wr_filt;
   logic [AW-1:0]  nxt_filt;
   logic [DW-1:0]  nxt_rdata;
   logic [DW-1:0]  status_word;

   assign wr_filt  = i_wr && (i_addr == `AFS_OFS_FILTER);
   assign nxt_filt = (i_wdata < DW'(`AFS_FILT_MIN)) ? `AFS_FILT_MIN :
                     (i_wdata > DW'(`AFS_FILT_MAX)) ? `AFS_FILT_MAX :
                     i_wdata[AW-1:0];

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         run_src_ff    <= `AFS_RUN_RST;
         freq_src_ff   <= `AFS_FREQ_RST;
         filt_ff       <= `AFS_FILT_RST;
         sel_opt_ff    <= `AFS_SEL_CURR;
         trim_opt_ff   <= `AFS_TRIM_NONE;
         sel_assign_ff <= 1'h1;
         sel_sync_ff   <= 2'h0;
         rdata_ff      <= '0;
      end else if (i_clk_en) begin
         sel_sync_ff <= {sel_sync_ff[0], i_current_voltage_select_input};
         rdata_ff    <= nxt_rdata;
         if (i_wr && i_addr == `AFS_OFS_RUN_SRC) begin
            run_src_ff <= i_wdata[2:0];
         end
         if (i_wr && i_addr == `AFS_OFS_FREQ_SRC) begin
            freq_src_ff <= i_wdata[2:0];
         end
         if (wr_filt) begin
            filt_ff <= nxt_filt;
         end
         if (i_wr && i_addr == `AFS_OFS_SEL_OPT) begin
            sel_opt_ff <= i_wdata[0];
         end
         if (i_wr && i_addr == `AFS_OFS_TRIM_OPT) begin
            trim_opt_ff <= i_wdata[1:0];
         end
         if (i_wr && i_addr == `AFS_OFS_SEL_ASSIGN) begin
            sel_assign_ff <= i_wdata[0];
         end
      end
   end

   assign status_word = DW'({o_route.rev_en, o_route.trim_en, o_route.chan,
                             o_dir_reverse, o_analog_active, sel_sync_ff[1],
                             o_run_source_monitor_output});
   assign nxt_rdata = !i_rd                          ? '0 :
                      (i_addr == `AFS_OFS_RUN_SRC)    ? DW'(run_src_ff) :
                      (i_addr == `AFS_OFS_FREQ_SRC)   ? DW'(freq_src_ff) :
                      (i_addr == `AFS_OFS_FILTER)     ? DW'(filt_ff) :
                      (i_addr == `AFS_OFS_SEL_OPT)    ? DW'(sel_opt_ff) :
                      (i_addr == `AFS_OFS_TRIM_OPT)   ? DW'(trim_opt_ff) :
                      (i_addr == `AFS_OFS_SEL_ASSIGN) ? DW'(sel_assign_ff) :
                      (i_addr == `AFS_OFS_STATUS)     ? status_word :
                      (i_addr == `AFS_OFS_FREQ_CMD)   ? DW'(o_freq_cmd) : '0;
   assign o_rdata = rdata_ff;

   // ---------------------------------------------------------------
   // moving average filter
   // ---------------------------------------------------------------
   filt_state_t       state_ff;
   filt_state_t       nxt_state;
   logic [AW-1:0]     wptr_ff;
   logic [AW-1:0]     fill_ff;
   logic [3*W-1:0]    smp_ff;
   logic [3*W-1:0]    old_smp;
   logic [SW-1:0]     sum_v_ff;
   logic [SW-1:0]     sum_c_ff;
   logic [SW-1:0]     sum_b_ff;
   logic [W-1:0]      avg_v_ff;
   logic [W-1:0]      avg_c_ff;
   logic [W-1:0]      avg_b_ff;
   logic              take;
   logic              full;
   logic [3*W-1:0]    old_gated;

   assign take      = (state_ff == ST_IDLE) && i_sample_valid;
   assign full      = (fill_ff == filt_ff);
   assign old_gated = full ? old_smp : '0;
   assign nxt_state = (state_ff == ST_IDLE) ? (take ? ST_UPD : ST_IDLE) :
                      (state_ff == ST_UPD)  ? ST_AVG : ST_IDLE;

   afs_sample_ram #(
      .DW (3*W),
      .AW (AW)
   ) u_ram (
      .i_clk_sys (i_clk_sys),
      .i_clk_en  (i_clk_en),
      .i_wr_en   (state_ff == ST_UPD),
      .i_wr_addr (wptr_ff),
      .i_wr_data (smp_ff),
      .i_rd_en   (take),
      .i_rd_addr (wptr_ff - filt_ff),
      .o_rd_data (old_smp)
   );

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff <= ST_IDLE;
         wptr_ff  <= '0;
         fill_ff  <= '0;
         smp_ff   <= '0;
         sum_v_ff <= '0;
         sum_c_ff <= '0;
         sum_b_ff <= '0;
         avg_v_ff <= '0;
         avg_c_ff <= '0;
         avg_b_ff <= '0;
      end else if (i_clk_en) begin
         state_ff <= nxt_state;
         if (take) begin
            smp_ff <= {i_samples.volt, i_samples.curr, flip_msb(i_samples.bip)};
         end
         if (wr_filt) begin
            // new window length: history restarts
            fill_ff  <= '0;
            sum_v_ff <= '0;
            sum_c_ff <= '0;
            sum_b_ff <= '0;
         end else if (state_ff == ST_UPD) begin
            wptr_ff  <= wptr_ff + 1'b1;
            fill_ff  <= full ? fill_ff : fill_ff + 1'b1;
            sum_v_ff <= sum_v_ff + SW'(smp_ff[3*W-1:2*W]) - SW'(old_gated[3*W-1:2*W]);
            sum_c_ff <= sum_c_ff + SW'(smp_ff[2*W-1:W]) - SW'(old_gated[2*W-1:W]);
            sum_b_ff <= sum_b_ff + SW'(smp_ff[W-1:0]) - SW'(old_gated[W-1:0]);
         end
         if (state_ff == ST_AVG) begin
            avg_v_ff <= avg_of(sum_v_ff, fill_ff);
            avg_c_ff <= avg_of(sum_c_ff, fill_ff);
            avg_b_ff <= flip_msb(avg_of(sum_b_ff, fill_ff));
         end
      end
   end

   // ---------------------------------------------------------------
   // routing and command
   // ---------------------------------------------------------------
   afs_pkg::route_t   route;
   logic              analog_sel;
   logic signed [CW-1:0] prim;
   logic signed [CW-1:0] bip_ext;
   logic signed [CW-1:0] cmd;
   logic signed [CW-1:0] cmd_lim;
   logic              neg;
   logic [W+1:0]      mag;

   assign route      = route_of(trim_opt_ff, sel_opt_ff, sel_assign_ff, sel_sync_ff[1]);
   assign analog_sel = (freq_src_ff == `AFS_FREQ_ANALOG);
   assign bip_ext    = CW'($signed(avg_b_ff));
   assign prim = (route.chan == afs_pkg::CH_VOLT) ? CW'({1'b0, avg_v_ff}) :
                 (route.chan == afs_pkg::CH_CURR) ? CW'({1'b0, avg_c_ff}) :
                 (route.chan == afs_pkg::CH_BIP)  ? bip_ext :
                 CW'({2'b00, avg_v_ff}) + CW'({2'b00, avg_c_ff});
   assign cmd     = prim + (route.trim_en ? bip_ext : '0);
   assign neg     = cmd[CW-1];
   assign cmd_lim = (neg && !route.rev_en) ? '0 : cmd;
   assign mag     = neg && route.rev_en ? (W+2)'(0) - cmd_lim[W+1:0] : cmd_lim[W+1:0];

   always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_run_source_monitor_output <= 1'b0;
         o_analog_active             <= 1'b0;
         o_route                     <= '0;
         o_freq_cmd                  <= '0;
         o_dir_reverse               <= 1'b0;
      end else if (i_clk_en) begin
         o_run_source_monitor_output <= (run_src_ff == `AFS_RUN_KEYPAD);
         o_analog_active             <= analog_sel;
         o_route                     <= route;
         o_freq_cmd                  <= analog_sel ? mag : '0;
         o_dir_reverse               <= analog_sel && route.rev_en && neg;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_monitor_keypad_on: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && run_src_ff == `AFS_RUN_KEYPAD |=> o_run_source_monitor_output)
      else $error("monitor not on for keypad run source");
   a_monitor_other_off: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && run_src_ff != `AFS_RUN_KEYPAD |=> !o_run_source_monitor_output)
      else $error("monitor on for non keypad run source");
   a_voltage_route_sel: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && sel_assign_ff && !sel_sync_ff[1] |=> o_route.chan == afs_pkg::CH_VOLT)
      else $error("voltage channel not chosen with select off");
   a_current_route_sel: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && sel_assign_ff && sel_sync_ff[1] && sel_opt_ff == `AFS_SEL_CURR
      |=> o_route.chan == afs_pkg::CH_CURR)
      else $error("current channel not chosen with select on");
   a_analog_source_gate: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && !analog_sel |=> !o_analog_active && o_freq_cmd == '0 && !o_dir_reverse)
      else $error("analog command while source not analog");
   a_filter_range_held: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      filt_ff >= `AFS_FILT_MIN && filt_ff <= `AFS_FILT_MAX && fill_ff <= filt_ff)
      else $error("filter setting or fill out of range");
   a_no_trim_opt00: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && sel_assign_ff && trim_opt_ff == `AFS_TRIM_NONE
      |=> !o_route.trim_en && (o_route.rev_en == (o_route.chan == afs_pkg::CH_BIP)))
      else $error("option 00 trim or reverse wrong");
   a_reverse_opt02: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && trim_opt_ff == `AFS_TRIM_REV |=> o_route.rev_en)
      else $error("option 02 did not permit reverse");
   a_reverse_needs_en: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      o_dir_reverse |-> o_route.rev_en && o_analog_active)
      else $error("reverse without reverse permission");
   a_unassigned_sum: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && !sel_assign_ff && trim_opt_ff != `AFS_TRIM_NONE
      |=> o_route.chan == afs_pkg::CH_SUM && o_route.trim_en)
      else $error("unassigned select did not sum channels");
   a_unipolar_opt01: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && !sel_assign_ff && trim_opt_ff == `AFS_TRIM_UNI |=> !o_dir_reverse)
      else $error("option 01 commanded reverse");
   a_filter_avg_step: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
      i_clk_en && take && !wr_filt ##1 i_clk_en && !wr_filt |=> state_ff == ST_AVG)
      else $error("filter pipeline did not advance");

endmodule // afs_select

//--- afs_sample_src.sv
/*
 analog sample source standing in for the converters that feed the select block.
 assumes the bench calls send() and that i_clk_sys is the block's own clock.
*/
`timescale 1ns/1ns
`include "afs_params.svh"

module afs_sample_src (
   // clock
   input  wire logic         i_clk_sys,
   // sample stream
   output afs_pkg::samples_t o_samples,
   output logic              o_sample_valid
);
   initial begin
      o_samples      = '0;
      o_sample_valid = 1'b0;
   end

   // one sample pulse, then scrambled lines and the filter's busy gap
   task automatic send(input logic [`AFS_SAMPLE_W-1:0] volt,
                       input logic [`AFS_SAMPLE_W-1:0] curr,
                       input logic [`AFS_SAMPLE_W-1:0] bip);
      @(posedge i_clk_sys);
      o_samples      <= '{volt, curr, bip};
      o_sample_valid <= 1'b1;
      @(posedge i_clk_sys);
      o_sample_valid <= 1'b0;
      o_samples      <= ~o_samples;
      repeat (3) @(posedge i_clk_sys);
   endtask
endmodule // afs_sample_src

//--- analog_freq_source_select_tb_top.sv
/*
 self-checking bench of the analog frequency source select block.
 assumes afs_pkg, afs_select and afs_sample_src are compiled before it.
*/
`timescale 1ns/1ns
`include "afs_params.svh"

module analog_freq_source_select_tb_top;
   logic              clk;
   logic              rst_n;
   logic              ce;
   logic              wr;
   logic              rd;
   logic              pin;
   logic [7:0]        addr;
   logic [15:0]       wdata;
   logic [15:0]       rdata;
   logic [15:0]       rv;
   logic              mon;
   logic              act;
   logic              dirrev;
   logic [11:0]       cmd;
   afs_pkg::route_t   route;
   afs_pkg::samples_t smp;
   logic              svalid;
   int                err_total;
   int                total_checks;

   afs_select #(.W(`AFS_SAMPLE_W), .DW(16)) dut_u (
      .i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(ce), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_samples(smp), .i_sample_valid(svalid),
      .i_current_voltage_select_input(pin), .o_run_source_monitor_output(mon),
      .o_analog_active(act), .o_route(route), .o_freq_cmd(cmd), .o_dir_reverse(dirrev));

   afs_sample_src src_u (.i_clk_sys(clk), .o_samples(smp), .o_sample_valid(svalid));

   always #20 clk = ~clk;

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic do_cmd(input logic [1:0] t, input logic [9:0] v, input logic [9:0] c,
                         input logic [9:0] b, input logic [15:0] ecmd, input logic edir);
      wr_reg(`AFS_OFS_TRIM_OPT, {14'h0000, t});
      settle(3);
      src_u.send(v, c, b);
      settle(5);
      chk("command magnitude", {4'h0, cmd}, ecmd);
      chk("command reverse", {15'h0000, dirrev}, {15'h0000, edir});
   endtask

   function automatic afs_pkg::route_t exp_route(input logic asg, input logic [1:0] t,
                                                 input logic s, input logic p);
      afs_pkg::route_t r;
      if (!asg) begin
         r.chan    = (t == 2'h0) ? afs_pkg::CH_BIP : afs_pkg::CH_SUM;
         r.trim_en = (t != 2'h0);
         r.rev_en  = (t != 2'h1);
      end else begin
         r.chan    = !p ? afs_pkg::CH_VOLT : (s ? afs_pkg::CH_BIP : afs_pkg::CH_CURR);
         r.trim_en = (t != 2'h0) && (r.chan != afs_pkg::CH_BIP);
         r.rev_en  = (r.chan == afs_pkg::CH_BIP) || (t == 2'h2);
      end
      return r;
   endfunction

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("watchdog expired");
      report_and_stop();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin : main
      logic [7:0]  ra [6];
      logic [15:0] rx [6];
      logic [15:0] fw [4];
      logic [15:0] fx [4];
      ra = '{`AFS_OFS_RUN_SRC, `AFS_OFS_FREQ_SRC, `AFS_OFS_FILTER, `AFS_OFS_SEL_OPT,
             `AFS_OFS_TRIM_OPT, `AFS_OFS_SEL_ASSIGN};
      rx = '{16'h0001, 16'h0001, 16'h0008, 16'h0000, 16'h0000, 16'h0001};
      fw = '{16'h0000, 16'h0001, 16'h001E, 16'h001F};
      fx = '{16'h0001, 16'h0001, 16'h001E, 16'h001E};
      clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; pin = 1'b0;
      addr = 8'h00; wdata = 16'h0000; err_total = 0; total_checks = 0;
      ce = 1'b1;
      settle(10);
      rst_n <= 1'b1;
      settle(3);
      chk("monitor after reset", {15'h0000, mon}, 16'h0000);
      chk("analog active after reset", {15'h0000, act}, 16'h0001);
      for (int i = 0; i < 6; i++) begin
         rd_reg(ra[i], rv);
         chk("reset value", rv, rx[i]);
      end
      wr_reg(8'h24, 16'hFFFF);
      rd_reg(8'h24, rv);
      chk("unmapped read", rv, 16'h0000);
      $display("test reset_values done");

      for (int v = 1; v <= 5; v++) begin
         wr_reg(`AFS_OFS_RUN_SRC, 16'(v));
         settle(3);
         chk("run source monitor", {15'h0000, mon}, {15'h0000, v == 2});
         rd_reg(`AFS_OFS_STATUS, rv);
         chk("status monitor bit", {15'h0000, rv[0]}, {15'h0000, v == 2});
      end
      settle(1);
      chk("read data after read", rdata, 16'h0000);
      $display("test run_source_monitor done");

      ce <= 1'b0;
      wr_reg(`AFS_OFS_RUN_SRC, 16'h0002);
      ce <= 1'b1;
      settle(3);
      chk("monitor with clock enable low", {15'h0000, mon}, 16'h0000);
      rd_reg(`AFS_OFS_RUN_SRC, rv);
      chk("write ignored while frozen", rv, 16'h0005);
      $display("test clock_enable done");

      for (int i = 0; i < 4; i++) begin
         wr_reg(`AFS_OFS_FILTER, fw[i]);
         rd_reg(`AFS_OFS_FILTER, rv);
         chk("filter setting clamp", rv, fx[i]);
      end
      $display("test filter_range done");

      for (int a = 0; a < 2; a++)
         for (int t = 0; t < 3; t++)
            for (int s = 0; s < 2; s++)
               for (int p = 0; p < 2; p++) begin
                  wr_reg(`AFS_OFS_SEL_ASSIGN, 16'(a));
                  wr_reg(`AFS_OFS_TRIM_OPT, 16'(t));
                  wr_reg(`AFS_OFS_SEL_OPT, 16'(s));
                  pin <= p[0];
                  settle(5);
                  chk("route", {12'h000, route}, {12'h000, exp_route(a[0], t[1:0], s[0], p[0])});
               end
      $display("test routing_table done");

      pin <= 1'b0;
      wr_reg(`AFS_OFS_FILTER, 16'h0001);
      wr_reg(`AFS_OFS_SEL_ASSIGN, 16'h0000);
      do_cmd(2'h0, 10'h064, 10'h064, 10'h39C, 16'h0064, 1'b1);
      do_cmd(2'h0, 10'h000, 10'h000, 10'h04D, 16'h004D, 1'b0);
      do_cmd(2'h1, 10'h12C, 10'h0C8, 10'h032, 16'h0226, 1'b0);
      do_cmd(2'h1, 10'h064, 10'h064, 10'h20C, 16'h0000, 1'b0);
      do_cmd(2'h2, 10'h064, 10'h064, 10'h20C, 16'h012C, 1'b1);
      wr_reg(`AFS_OFS_FREQ_SRC, 16'h0003);
      do_cmd(2'h1, 10'h12C, 10'h0C8, 10'h032, 16'h0000, 1'b0);
      chk("analog active off", {15'h0000, act}, 16'h0000);
      $display("test command_value done");

      wr_reg(`AFS_OFS_FREQ_SRC, 16'h0001);
      wr_reg(`AFS_OFS_SEL_ASSIGN, 16'h0001);
      wr_reg(`AFS_OFS_TRIM_OPT, 16'h0000);
      wr_reg(`AFS_OFS_SEL_OPT, 16'h0000);
      wr_reg(`AFS_OFS_FILTER, 16'h0002);
      settle(3);
      src_u.send(10'h064, 10'h00A, 10'h000);
      settle(5);
      chk("average while filling", {4'h0, cmd}, 16'h0064);
      src_u.send(10'h12D, 10'h014, 10'h000);
      settle(5);
      chk("average of two", {4'h0, cmd}, 16'h00C8);
      pin <= 1'b1;
      settle(5);
      src_u.send(10'h1F5, 10'h028, 10'h000);
      settle(5);
      chk("current channel window", {4'h0, cmd}, 16'h001E);
      rd_reg(`AFS_OFS_FREQ_CMD, rv);
      chk("command register", rv, 16'h001E);
      rd_reg(`AFS_OFS_STATUS, rv);
      chk("status word", rv, 16'h0016);
      $display("test moving_average done");
      report_and_stop();
   end
endmodule // analog_freq_source_select_tb_top
